// [logic/cbc_consts.svh]
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH

// Register byte offsets
`define CBC_OFF_CTRL 8'h00
`define CBC_OFF_BP_EN 8'h04
`define CBC_OFF_DAR0 8'h08
`define CBC_OFF_DAR1 8'h0C
`define CBC_OFF_DAR2 8'h10
`define CBC_OFF_DAR3 8'h14
`define CBC_OFF_STATUS 8'h18
`define CBC_OFF_MC_ADDR 8'h1C
`define CBC_OFF_MC_CTRL 8'h20
`define CBC_OFF_IRQ_STAT 8'h24
`define CBC_OFF_IRQ_MASK 8'h28

// Control register fields
`define CBC_CTRL_MCE 0
`define CBC_CTRL_SEL_LO 1
`define CBC_CTRL_SEL_HI 2
`define CBC_CTRL_RESET 3'h0

// Interrupt status fields
`define CBC_IRQ_DONE 0
`define CBC_IRQ_BACKOFF 1
`define CBC_IRQ_BUS_CHECK_IN_N 2
`define CBC_IRQ_BREAK 3
`define CBC_IRQ_W 4

// Bus clock phase counts
`define CBC_PH_TWO_THIRDS 2'h2
`define CBC_PH_ONE_HALF 2'h1

// Strap capture delay after reset release
`define CBC_STRAP_WAIT 2'h3

// Last beat index of a burst
`define CBC_LAST_BEAT 2'h3

`endif

// [logic/cbc_pkg.sv]
package cbc_pkg;

    typedef enum logic [1:0] {
        CBC_IDLE = 2'b00,
        CBC_T1 = 2'b01,
        CBC_T2 = 2'b10,
        CBC_HOLD = 2'b11
    } cbc_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic cacheable;
        logic [31:0] addr;
    } cbc_req_s;

    typedef struct packed {
        logic ads;
        logic write;
        logic cacheable_n;
        logic [31:0] addr;
    } cbc_bus_s;

endpackage : cbc_pkg

// [logic/cbc_top.sv]
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "cbc_consts.svh"

module cbc_top
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire cbc_req_s req_i,
    output logic req_done_o,
    output logic cache_fill_o,
    input wire logic bus_ratio_strap_i,
    input wire logic backoff_in_n_i,
    input wire logic burst_ready_in_n_i,
    input wire logic bus_check_in_n_i,
    input wire logic cache_enable_in_n_i,
    output cbc_bus_s bus_o,
    output logic bus_float_o,
    output logic bus_request_out_o,
    output logic bus_en_o,
    output logic [1:0] breakpoint_match_out_o,
    output logic [1:0] perfmon_or_breakpoint_out_o,
    output logic machine_check_o,
    output logic irq_o
);

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    function automatic logic line_match(input logic [31:0] a, input logic [31:0] b);
        line_match = (a[31:3] == b[31:3]);
    endfunction : line_match

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pin_s1_q <= 5'h1F;
            pin_s2_q <= 5'h1F;
        end
        else
        begin
            pin_s1_q <= {bus_ratio_strap_i, backoff_in_n_i, burst_ready_in_n_i,
                         bus_check_in_n_i, cache_enable_in_n_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    logic strap_s;
    logic backoff;
    logic burst_ready_in_n;
    logic bus_check_in_n;
    logic ken;
    assign strap_s = pin_s2_q[4];
    assign backoff = !pin_s2_q[3];
    assign burst_ready_in_n = !pin_s2_q[2];
    assign bus_check_in_n = !pin_s2_q[1];
    assign ken = !pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Ratio strap capture
    logic [1:0] strap_wait_q;
    logic strap_done_q;
    logic ratio_two_thirds_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_wait_q <= 2'h0;
            strap_done_q <= 1'b0;
            ratio_two_thirds_q <= 1'b1;
        end
        else if (!strap_done_q)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == `CBC_STRAP_WAIT)
            begin
                strap_done_q <= 1'b1;
                ratio_two_thirds_q <= strap_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus clock enable divider
    logic [1:0] phase_q;
    logic [1:0] phase_last;
    logic bus_en_q;
    assign phase_last = ratio_two_thirds_q ? `CBC_PH_TWO_THIRDS : `CBC_PH_ONE_HALF;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            phase_q <= 2'h0;
            bus_en_q <= 1'b0;
        end
        else if (strap_done_q)
        begin
            phase_q <= (phase_q == phase_last) ? 2'h0 : phase_q + 2'h1;
            bus_en_q <= (phase_q != phase_last);
        end
    end

    assign bus_en_o = bus_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0] ctrl_q;
    logic [3:0] bp_en_q;
    logic [31:0] dar_q [0:3];
    logic [31:0] mc_addr_q;
    logic [1:0] mc_ctrl_q;
    logic [`CBC_IRQ_W-1:0] irq_stat_q;
    logic [`CBC_IRQ_W-1:0] irq_mask_q;
    cbc_state_e state_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= `CBC_CTRL_RESET;
            bp_en_q <= 4'h0;
            irq_mask_q <= 4'h0;
            for (int i = 0; i < 4; i++)
            begin
                dar_q[i] <= 32'h0;
            end
        end
        else if (reg_we_i)
        begin
            if (reg_hit(reg_addr_i, `CBC_OFF_CTRL))
                ctrl_q <= reg_wdata_i[2:0];
            else if (reg_hit(reg_addr_i, `CBC_OFF_BP_EN))
                bp_en_q <= reg_wdata_i[3:0];
            else if (reg_hit(reg_addr_i, `CBC_OFF_DAR0))
                dar_q[0] <= reg_wdata_i;
            else if (reg_hit(reg_addr_i, `CBC_OFF_DAR1))
                dar_q[1] <= reg_wdata_i;
            else if (reg_hit(reg_addr_i, `CBC_OFF_DAR2))
                dar_q[2] <= reg_wdata_i;
            else if (reg_hit(reg_addr_i, `CBC_OFF_DAR3))
                dar_q[3] <= reg_wdata_i;
            else if (reg_hit(reg_addr_i, `CBC_OFF_IRQ_MASK))
                irq_mask_q <= reg_wdata_i[3:0];
        end
    end

    // Read data one cycle later
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= 32'h0;
        else if (!reg_re_i)
            reg_rdata_o <= 32'h0;
        else if (reg_hit(reg_addr_i, `CBC_OFF_CTRL))
            reg_rdata_o <= {29'h0, ctrl_q};
        else if (reg_hit(reg_addr_i, `CBC_OFF_BP_EN))
            reg_rdata_o <= {28'h0, bp_en_q};
        else if (reg_hit(reg_addr_i, `CBC_OFF_DAR0))
            reg_rdata_o <= dar_q[0];
        else if (reg_hit(reg_addr_i, `CBC_OFF_DAR1))
            reg_rdata_o <= dar_q[1];
        else if (reg_hit(reg_addr_i, `CBC_OFF_DAR2))
            reg_rdata_o <= dar_q[2];
        else if (reg_hit(reg_addr_i, `CBC_OFF_DAR3))
            reg_rdata_o <= dar_q[3];
        else if (reg_hit(reg_addr_i, `CBC_OFF_STATUS))
            reg_rdata_o <= {28'h0, state_q, strap_done_q, ratio_two_thirds_q};
        else if (reg_hit(reg_addr_i, `CBC_OFF_MC_ADDR))
            reg_rdata_o <= mc_addr_q;
        else if (reg_hit(reg_addr_i, `CBC_OFF_MC_CTRL))
            reg_rdata_o <= {30'h0, mc_ctrl_q};
        else if (reg_hit(reg_addr_i, `CBC_OFF_IRQ_STAT))
            reg_rdata_o <= {28'h0, irq_stat_q};
        else if (reg_hit(reg_addr_i, `CBC_OFF_IRQ_MASK))
            reg_rdata_o <= {28'h0, irq_mask_q};
        else
            reg_rdata_o <= 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer
    logic [1:0] beat_q;
    logic burst_q;
    logic first_q;
    logic ev_done;
    logic ev_backoff;
    logic ev_bus_check_in_n;
    logic burst_now;
    logic last_beat;

    // Burst length from cacheability and cache enable
    assign burst_now = first_q ? (!bus_o.cacheable_n && (bus_o.write || ken)) : burst_q;
    assign last_beat = !burst_now || (beat_q == `CBC_LAST_BEAT);
    assign ev_backoff = bus_en_q && backoff && (state_q == CBC_T1 || state_q == CBC_T2);
    assign ev_done = bus_en_q && (state_q == CBC_T2) && !backoff && burst_ready_in_n && last_beat;
    assign ev_bus_check_in_n = bus_en_q && (state_q == CBC_T2) && !backoff && bus_check_in_n;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= CBC_IDLE;
            bus_o <= '{ads: 1'b0, write: 1'b0, cacheable_n: 1'b1, addr: 32'h0};
            bus_float_o <= 1'b0;
            beat_q <= 2'h0;
            burst_q <= 1'b0;
            first_q <= 1'b0;
        end
        else if (bus_en_q)
        begin
            bus_o.ads <= 1'b0;
            case (state_q)
                CBC_IDLE:
                begin
                    bus_float_o <= backoff;
                    if (req_i.valid && !req_done_o && !backoff)
                    begin
                        state_q <= CBC_T1;
                        bus_o <= '{ads: 1'b1, write: req_i.write,
                                   cacheable_n: !req_i.cacheable,
                                   addr: req_i.addr};
                    end
                end
                CBC_T1, CBC_T2:
                begin
                    if (backoff)
                    begin
                        state_q <= CBC_HOLD;
                        bus_float_o <= 1'b1;
                        beat_q <= 2'h0;
                    end
                    else if (state_q == CBC_T1)
                    begin
                        state_q <= CBC_T2;
                        first_q <= 1'b1;
                    end
                    else if (burst_ready_in_n)
                    begin
                        first_q <= 1'b0;
                        burst_q <= burst_now;
                        beat_q <= beat_q + 2'h1;
                        if (last_beat)
                        begin
                            state_q <= CBC_IDLE;
                            beat_q <= 2'h0;
                        end
                    end
                end
                CBC_HOLD:
                begin
                    if (!backoff)
                    begin
                        state_q <= CBC_T1;
                        bus_o.ads <= 1'b1;
                        bus_float_o <= 1'b0;
                    end
                end
                default:
                    state_q <= CBC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request side outputs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            req_done_o <= 1'b0;
            cache_fill_o <= 1'b0;
            bus_request_out_o <= 1'b0;
        end
        else
        begin
            req_done_o <= ev_done;
            // Fill only when cacheable and cache enabled
            cache_fill_o <= ev_done && !bus_o.write && burst_now;
            bus_request_out_o <= req_i.valid && !req_done_o && !ev_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine check capture
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mc_addr_q <= 32'h0;
            mc_ctrl_q <= 2'h0;
            machine_check_o <= 1'b0;
        end
        else
        begin
            machine_check_o <= ev_bus_check_in_n && ctrl_q[`CBC_CTRL_MCE];
            if (ev_bus_check_in_n)
            begin
                mc_addr_q <= bus_o.addr;
                mc_ctrl_q <= {bus_o.write, !bus_o.cacheable_n};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Breakpoint and monitor pins
    logic [3:0] bp_hit;
    logic ev_break;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            bp_hit[i] = bp_en_q[i] && line_match(dar_q[i], bus_o.addr);
        end
    end
    assign ev_break = bus_o.ads && (bp_hit != 4'h0);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            breakpoint_match_out_o <= 2'h0;
            perfmon_or_breakpoint_out_o <= 2'h0;
        end
        else
        begin
            breakpoint_match_out_o <= bus_o.ads ? bp_hit[3:2] : 2'h0;
            perfmon_or_breakpoint_out_o[1] <= ctrl_q[`CBC_CTRL_SEL_HI] ?
                (bus_o.ads && bp_hit[1]) : ev_backoff;
            perfmon_or_breakpoint_out_o[0] <= ctrl_q[`CBC_CTRL_SEL_LO] ?
                (bus_o.ads && bp_hit[0]) : ev_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by read, set wins
    logic [`CBC_IRQ_W-1:0] irq_set;
    logic irq_clr;
    assign irq_set = {ev_break, ev_bus_check_in_n, ev_backoff, ev_done};
    assign irq_clr = reg_re_i && reg_hit(reg_addr_i, `CBC_OFF_IRQ_STAT);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_stat_q <= 4'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_clr ? 4'h0 : irq_stat_q) | irq_set;
            irq_o <= (((irq_clr ? 4'h0 : irq_stat_q) | irq_set) & irq_mask_q) != 4'h0;
        end
    end

endmodule : cbc_top
`default_nettype wire

// [verif/cbc_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module cbc_chk
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cbc_req_s req_i,
    input wire logic req_done_o,
    input wire logic cache_fill_o,
    input wire logic bus_check_in_n_i,
    input wire cbc_bus_s bus_o,
    input wire logic bus_float_o,
    input wire logic bus_request_out_o,
    input wire logic bus_en_o,
    input wire logic machine_check_o
);
    logic [3:0] chk_age_q;

    // Cycles since bus check pin was last low
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            chk_age_q <= 4'hF;
        else if (!bus_check_in_n_i)
            chk_age_q <= 4'h0;
        else if (chk_age_q != 4'hF)
            chk_age_q <= chk_age_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_hold_no_ads;
        bus_float_o |-> !bus_o.ads;
    endproperty
    a_hold_no_ads: assert property (p_hold_no_ads)
        else $error("address strobe while bus floated");
    property p_ads_on_edge;
        $rose(bus_o.ads) |-> $past(bus_en_o);
    endproperty
    a_ads_on_edge: assert property (p_ads_on_edge)
        else $error("address strobe off a bus edge");
    property p_en_gap;
        $fell(bus_en_o) |=> bus_en_o;
    endproperty
    a_en_gap: assert property (p_en_gap)
        else $error("bus enable low two cycles");
    property p_en_run;
        bus_en_o && $past(bus_en_o) |=> !bus_en_o;
    endproperty
    a_en_run: assert property (p_en_run)
        else $error("bus enable high three cycles");
    property p_done_pulse;
        req_done_o |=> !req_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    property p_fill;
        cache_fill_o |-> (req_done_o && !req_i.write && req_i.cacheable);
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill without cacheable read");
    property p_cache_pin;
        $rose(bus_o.ads) |-> (bus_o.cacheable_n == !req_i.cacheable)
            && (bus_o.write == req_i.write) && (bus_o.addr == req_i.addr);
    endproperty
    a_cache_pin: assert property (p_cache_pin)
        else $error("cycle attributes differ from request");
    property p_bus_request_out;
        $rose(bus_o.ads) |-> bus_request_out_o;
    endproperty
    a_bus_request_out: assert property (p_bus_request_out)
        else $error("bus request low at cycle start");
    property p_mc;
        machine_check_o |-> chk_age_q <= 4'h6;
    endproperty
    a_mc: assert property (p_mc)
        else $error("machine check without bus check");
endmodule : cbc_chk
`default_nettype wire

// [verif/cbc_sys_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cbc_sys_model
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cbc_bus_s bus_i,
    input wire logic bus_en_i,
    input wire logic bus_float_i,
    input wire logic [3:0] wait_i,
    input wire logic ken_off_i,
    output logic burst_ready_in_n_o,
    output logic cache_enable_in_n_o
);
    logic ads_q;
    logic [3:0] wait_q;
    logic [2:0] beats_q;

    ////////////////////////////////////////////////////////////
    assign cache_enable_in_n_o = ken_off_i;

    // Beat fired after a bus enable cycle lands on a bus edge three clocks on at the two-thirds ratio
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ads_q <= 1'b0;
            wait_q <= 4'h0;
            beats_q <= 3'h0;
            burst_ready_in_n_o <= 1'b1;
        end
        else
        begin
            ads_q <= bus_i.ads;
            burst_ready_in_n_o <= 1'b1;
            if (bus_float_i)
                beats_q <= 3'h0;
            else if (bus_i.ads && !ads_q)
            begin
                beats_q <= (!bus_i.cacheable_n && (bus_i.write || !ken_off_i)) ? 3'h4 : 3'h1;
                wait_q <= wait_i;
            end
            else if (beats_q != 3'h0 && bus_en_i)
            begin
                if (wait_q != 4'h0)
                    wait_q <= wait_q - 4'h1;
                else
                begin
                    burst_ready_in_n_o <= 1'b0;
                    beats_q <= beats_q - 3'h1;
                end
            end
        end
    end
endmodule : cbc_sys_model
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cbc_consts.svh"
module tb
    import cbc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [31:0] reg_rdata_o;
    cbc_req_s req_i = '0;
    logic req_done_o, cache_fill_o, bus_float_o, bus_request_out_o, bus_en_o;
    logic machine_check_o, irq_o, burst_ready_in_n_i, cache_enable_in_n_i;
    logic bus_ratio_strap_i = 1'b1;
    logic backoff_in_n_i = 1'b1;
    logic bus_check_in_n_i = 1'b1;
    cbc_bus_s bus_o;
    logic [1:0] breakpoint_match_out_o, perfmon_or_breakpoint_out_o;
    logic [3:0] wait_v = 4'h0;
    logic ken_off = 1'b0;
    logic rd_pend = 1'b0;
    logic ads_d = 1'b0;
    logic [5:0] acc = 6'h0;
    logic [31:0] rd_q[$];
    logic [6:0] done_q[$];
    integer seed = 73697;
    int n_errors = 0;
    int n_checks = 0;
    int n_ads = 0;

    always #5 clk_i = ~clk_i;

    cbc_top i_cbc_top (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_done_o(req_done_o),
        .cache_fill_o(cache_fill_o), .bus_ratio_strap_i(bus_ratio_strap_i),
        .backoff_in_n_i(backoff_in_n_i), .burst_ready_in_n_i(burst_ready_in_n_i),
        .bus_check_in_n_i(bus_check_in_n_i), .cache_enable_in_n_i(cache_enable_in_n_i),
        .bus_o(bus_o), .bus_float_o(bus_float_o), .bus_request_out_o(bus_request_out_o),
        .bus_en_o(bus_en_o), .breakpoint_match_out_o(breakpoint_match_out_o),
        .perfmon_or_breakpoint_out_o(perfmon_or_breakpoint_out_o),
        .machine_check_o(machine_check_o), .irq_o(irq_o));
    cbc_sys_model i_cbc_sys_model (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_o),
        .bus_en_i(bus_en_o), .bus_float_i(bus_float_o), .wait_i(wait_v),
        .ken_off_i(ken_off), .burst_ready_in_n_o(burst_ready_in_n_i),
        .cache_enable_in_n_o(cache_enable_in_n_i));

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        rd_q.push_back(e);
        @(posedge clk_i);
        reg_re_i <= 1'b0;
    endtask : rd

    // Expected done note: fill, monitor pins, breakpoints, check, float
    task automatic req(input logic w, input logic c, input logic [31:0] a, input logic [6:0] e);
        int i;
        @(posedge clk_i);
        req_i <= '{1'b1, w, c, a};
        done_q.push_back(e);
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk_i);
            if (req_done_o === 1'b1)
                break;
        end
        req_i.valid <= 1'b0;
        if (i == 300)
        begin
            n_errors++;
            wrap_up();
        end
    endtask : req

    task automatic inject(input logic bc, input int dly, input int len);
        int i;
        for (i = 0; i < 300 && bus_o.ads !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 300)
        begin
            n_errors++;
            wrap_up();
        end
        repeat (dly) @(posedge clk_i);
        if (bc)
            bus_check_in_n_i <= 1'b0;
        else
            backoff_in_n_i <= 1'b0;
        repeat (len) @(posedge clk_i);
        bus_check_in_n_i <= 1'b1;
        backoff_in_n_i <= 1'b1;
    endtask : inject

    // Result watcher
    always @(posedge clk_i)
    begin
        if (rd_pend)
            check("read data", reg_rdata_o, rd_q.pop_front());
        rd_pend <= reg_re_i;
        if (bus_o.ads && !ads_d)
            n_ads++;
        ads_d <= bus_o.ads;
        if (req_done_o === 1'b1)
        begin
            check("done", {25'h0, cache_fill_o, acc | {perfmon_or_breakpoint_out_o,
                breakpoint_match_out_o, machine_check_o, bus_float_o}},
                {25'h0, done_q.pop_front()});
            acc <= 6'h0;
        end
        else
            acc <= acc | {perfmon_or_breakpoint_out_o, breakpoint_match_out_o,
                machine_check_o, bus_float_o};
    end

    initial
    begin
        logic [31:0] a;
        int k;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(`CBC_OFF_STATUS, 32'h3);
        rd(`CBC_OFF_CTRL, 32'h0);
        rd(8'h2C, 32'h0);
        rd(`CBC_OFF_IRQ_STAT, 32'h0);
        wr(`CBC_OFF_IRQ_MASK, 32'hF);
        wr(`CBC_OFF_CTRL, 32'h1);
        for (k = 0; k < 8; k++)
        begin
            a = $random(seed);
            wait_v <= {2'h0, a[1:0]};
            ken_off <= k[2];
            req(k[0], k[1], {a[31:3], 3'h0}, {!k[0] && k[1] && !k[2], 6'h10});
        end
        repeat (2) @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h1);
        rd(`CBC_OFF_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h0);
        n_ads = 0;
        wait_v <= 4'h6;
        ken_off <= 1'b0;
        fork
            req(1'b0, 1'b0, 32'h00001000, 7'h31);
            inject(1'b0, 2, 10);
        join
        check("cycle starts", n_ads, 32'h2);
        rd(`CBC_OFF_IRQ_STAT, 32'h3);
        wr(`CBC_OFF_IRQ_MASK, 32'h0);
        fork
            req(1'b1, 1'b1, 32'h00002468, 7'h12);
            inject(1'b1, 2, 2);
        join
        check("irq", {31'h0, irq_o}, 32'h0);
        rd(`CBC_OFF_MC_ADDR, 32'h00002468);
        rd(`CBC_OFF_MC_CTRL, 32'h3);
        wr(`CBC_OFF_IRQ_MASK, 32'hF);
        repeat (2) @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h1);
        rd(`CBC_OFF_IRQ_STAT, 32'h5);
        wr(`CBC_OFF_CTRL, 32'h6);
        wr(`CBC_OFF_DAR0, 32'h00003000);
        wr(`CBC_OFF_DAR2, 32'h00003000);
        wr(`CBC_OFF_BP_EN, 32'h5);
        req(1'b0, 1'b0, 32'h00003004, 7'h14);
        rd(`CBC_OFF_IRQ_STAT, 32'h9);
        wrap_up();
    end
endmodule : tb

bind cbc_top cbc_chk i_cbc_chk (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
    .req_done_o(req_done_o), .cache_fill_o(cache_fill_o),
    .bus_check_in_n_i(bus_check_in_n_i), .bus_o(bus_o), .bus_float_o(bus_float_o),
    .bus_request_out_o(bus_request_out_o), .bus_en_o(bus_en_o),
    .machine_check_o(machine_check_o));
`default_nettype wire
